// ==== design/mbda_top.sv ====
// Purpose: modbus rtu slave data access, byte stream in and out
// Assumes: uart outside delivers bytes, rx and tx synchronous to clk_in
// Notes: exceptions and loopback are not served; unknown requests stay silent
`timescale 1ns/1ps
`include "mbda_map.svh"
module mbda_top
   import mbda_pkg::*;
#(
   parameter int unsigned CLK_HZ     = 50_000_000,
   parameter int unsigned BAUD_RATE  = 9600,
   parameter int unsigned GAP_CYCLES = int'((64'(CLK_HZ) * `MBDA_CHAR_BITS * `MBDA_GAP_TENTHS
                                       + 64'(BAUD_RATE) * `MBDA_TENTHS - 1) / (64'(BAUD_RATE) * `MBDA_TENTHS)),
   parameter int unsigned RX_DEPTH   = 64
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   // configuration
   input  wire logic [7:0]  slave_addr_in,
   // process data
   input  wire logic [15:0] level_eng_in,
   input  wire logic [31:0] temp_float_in,
   input  wire logic [15:0] alarm_bits_in,
   input  wire logic [15:0] diag_bits_in,
   // received bytes
   input  wire logic [7:0]  rx_data_in,
   input  wire logic        rx_valid_in,
   // transmitted bytes
   output logic      [7:0]  tx_data_out,
   output logic             tx_valid_out,
   input  wire logic        tx_ready_in,
   // configured state
   output logic      [15:0] cmd_bits_out,
   output logic      [15:0] unit_code_out,
   output logic      [15:0] level_scaled_out,
   output logic      [31:0] temp_setpoint_out,
   output logic             config_error_out
);
   localparam int unsigned AW = $clog2(RX_DEPTH);

   mbda_state_t state, next_state;
   mbda_req_t   req;
   logic [7:0]  rx_buf [RX_DEPTH];
   logic        rx_wr;
   logic [7:0]  rx_len, next_rx_len;
   logic [15:0] crc_rx, next_crc_rx;
   logic [31:0] gap_cnt, next_gap_cnt;
   logic [15:0] item, next_item;
   logic [15:0] crc_tx, next_crc_tx;
   logic [7:0]  tx_data, next_tx_data;
   logic        tx_valid, next_tx_valid;
   logic [15:0] cmd_bits, next_cmd_bits;
   logic [15:0] unit_code, next_unit_code;
   logic [15:0] ceiling, next_ceiling;
   logic [15:0] smin, next_smin;
   logic [15:0] smax, next_smax;
   logic [31:0] setpoint, next_setpoint;
   logic        cfg_err, next_cfg_err;
   logic [15:0] level_scaled;
   logic [31:0] prod;
   logic [15:0] span;
   logic [15:0] resp_len, n_items, exp_len, pos, crc_next;
   logic        frame_ok, cnt_ok, w16_en, bw_en, bw_val;
   logic [15:0] w16_addr, w16_data, bw_addr;
   logic [7:0]  b8;

   // ----------
   // helpers
   // ----------
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ `MBDA_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] rxb(input logic [15:0] i);
      if (i < 16'(RX_DEPTH)) begin
         return rx_buf[i[AW-1:0]];
      end
      return 8'h00;
   endfunction

   // holding and input registers are one storage
   function automatic logic [15:0] rd16(input logic [15:0] a);
      case (a) // RULE21
         `MBDA_REG_LEVEL:    return level_scaled;
         `MBDA_REG_ALARM:    return alarm_bits_in; // RULE9
         `MBDA_REG_DIAG:     return diag_bits_in;
         `MBDA_REG_CMD:      return cmd_bits; // RULE8
         `MBDA_REG_UNIT:     return unit_code; // RULE7
         `MBDA_REG_CEILING:  return ceiling;
         `MBDA_REG_SMIN:     return smin;
         `MBDA_REG_SMAX:     return smax;
         `MBDA_REG_TPAIR_HI: return temp_float_in[31:16]; // RULE11 RULE12
         `MBDA_REG_TPAIR_LO: return temp_float_in[15:0];
         default:            return 16'h0000; // RULE22
      endcase
   endfunction

   function automatic logic [31:0] rdf(input logic [15:0] a);
      case (a)
         `MBDA_FLT_TEMP:     return temp_float_in; // RULE16
         `MBDA_FLT_SETPOINT: return setpoint;
         default:            return 32'h0000_0000; // RULE13
      endcase
   endfunction

   // coils and discrete inputs are one storage
   function automatic logic bit_rd(input logic [15:0] b);
      logic [15:0] w;
      case (b[15:4]) // RULE21
         `MBDA_BITW_ALARM: w = alarm_bits_in; // RULE19
         `MBDA_BITW_DIAG:  w = diag_bits_in;
         `MBDA_BITW_CMD:   w = cmd_bits;
         default:          w = 16'h0000;
      endcase
      return w[b[3:0]]; // RULE17
   endfunction

   function automatic logic [15:0] bit_bytes(input logic [15:0] c);
      return (c + 16'h0007) >> 3;
   endfunction

   function automatic logic [7:0] resp_byte(input logic [15:0] i);
      logic [15:0] k;
      logic [15:0] p;
      logic [15:0] r16;
      logic [31:0] r32;
      logic [7:0]  r;
      k = i - 16'h0003;
      r = 8'h00;
      if (i < 16'h0002) begin
         return rxb(i);
      end
      case (req.func)
         `MBDA_FC_RD_BITS, `MBDA_FC_RD_INBITS: begin
            if (i == 16'h0002) begin
               return 8'(bit_bytes(req.count));
            end
            for (int j = 0; j < 8; j++) begin
               p = {k[12:0], 3'b000} + 16'(j);
               r[j] = (p < req.count) && bit_rd(req.start + p); // RULE18
            end
            return r;
         end
         `MBDA_FC_RD_REGS, `MBDA_FC_RD_INREGS: begin
            if (i == 16'h0002) begin
               return 8'(req.count << 1); // RULE3 RULE12
            end
            r16 = rd16(req.start + {1'b0, k[15:1]});
            return k[0] ? r16[7:0] : r16[15:8]; // RULE3
         end
         `MBDA_FC_RD_FLT: begin
            if (i < 16'h0004) begin
               return rxb(i); // RULE14
            end
            k = i - 16'h0004;
            r32 = rdf(req.start + {2'b00, k[15:2]});
            case (k[1:0]) // RULE10
               2'b00:   return r32[31:24];
               2'b01:   return r32[23:16];
               2'b10:   return r32[15:8];
               default: return r32[7:0];
            endcase
         end
         `MBDA_FC_WR_FLT: return rxb(i + 16'h0002); // RULE15
         default: return rxb(i);
      endcase
   endfunction

   // ----------
   // request decode
   // ----------
   always_comb begin
      req.addr  = rx_buf[0];
      req.func  = rx_buf[1];
      req.start = {rx_buf[2], rx_buf[3]};
      req.count = {rx_buf[4], rx_buf[5]};
      req.bytes = rx_buf[6];
      exp_len   = `MBDA_LEN_FIXED;
      n_items   = req.count;
      resp_len  = `MBDA_LEN_FIXED - 16'h0002;
      cnt_ok    = (req.count != 16'h0000) && (req.count <= `MBDA_MAX_ITEMS);
      case (req.func)
         `MBDA_FC_RD_BITS, `MBDA_FC_RD_INBITS: begin
            n_items  = 16'h0000;
            resp_len = 16'h0003 + bit_bytes(req.count);
         end
         `MBDA_FC_RD_REGS, `MBDA_FC_RD_INREGS: begin
            n_items  = 16'h0000;
            resp_len = 16'h0003 + (req.count << 1);
         end
         `MBDA_FC_WR_BIT, `MBDA_FC_WR_REG: begin
            n_items = 16'h0001;
            cnt_ok  = 1'b1;
         end
         `MBDA_FC_WR_BITS: begin
            exp_len = `MBDA_LEN_HDR + {8'h00, req.bytes};
            cnt_ok  = cnt_ok && ({8'h00, req.bytes} == bit_bytes(req.count));
         end
         `MBDA_FC_WR_REGS: begin
            exp_len = `MBDA_LEN_HDR + {8'h00, req.bytes};
            cnt_ok  = cnt_ok && ({8'h00, req.bytes} == (req.count << 1));
         end
         `MBDA_FC_RD_FLT: begin
            n_items  = 16'h0000;
            resp_len = 16'h0004 + (req.count << 2);                         // RULE14
         end
         `MBDA_FC_WR_FLT: begin
            exp_len  = `MBDA_LEN_FIXED + (req.count << 2);                  // RULE15
            resp_len = 16'h0004;
         end
         default: exp_len = 16'h0000;
      endcase
      // zero residue over data plus crc means the check field matched
      frame_ok = (rx_len >= `MBDA_LEN_MIN) && (crc_rx == 16'h0000)          // RULE23 RULE24
                 && (slave_addr_in >= `MBDA_ADDR_MIN) && (slave_addr_in <= `MBDA_ADDR_MAX)
                 && (req.addr == slave_addr_in)                             // RULE20 RULE24
                 && (exp_len != 16'h0000) && ({8'h00, rx_len} == exp_len) && cnt_ok;
   end

   // ----------
   // integer scaling
   // ----------
   // combinational divide: simple, but sets the timing floor of the block
   always_comb begin
      span = smax - smin;
      prod = 32'(level_eng_in - smin) * 32'(ceiling);
      if ((level_eng_in < smin) || (level_eng_in > smax)) begin
         level_scaled = ceiling + 16'h0001;                                 // RULE4
      end else if (span == 16'h0000) begin
         level_scaled = 16'h0000;
      end else begin
         level_scaled = 16'(prod / 32'(span));                              // RULE1 RULE2
      end
   end

   // ----------
   // frame engine
   // ----------
   always_comb begin
      next_state     = state;
      next_rx_len    = rx_len;
      next_crc_rx    = crc_rx;
      next_item      = item;
      next_crc_tx    = crc_tx;
      next_tx_data   = tx_data;
      next_tx_valid  = tx_valid;
      next_gap_cnt   = gap_cnt;
      rx_wr          = 1'b0;
      w16_en         = 1'b0;
      w16_addr       = req.start;
      w16_data       = {rxb(`MBDA_POS_VAL), rxb(`MBDA_POS_VAL + 16'h0001)};
      bw_en          = 1'b0;
      bw_addr        = req.start;
      bw_val         = 1'b0;
      pos            = req.start + item;
      b8             = rxb(`MBDA_POS_DATA + {3'b000, item[15:3]});
      crc_next       = crc_step(crc_tx, tx_data);
      if (rx_valid_in) begin
         next_gap_cnt = 32'h0000_0000;
      end else if (gap_cnt < 32'(GAP_CYCLES)) begin
         next_gap_cnt = gap_cnt + 32'h0000_0001;
      end
      case (state)
         MBDA_RECV: begin
            if (rx_valid_in) begin
               if (rx_len < 8'(RX_DEPTH)) begin
                  rx_wr       = 1'b1;
                  next_rx_len = rx_len + 8'h01;
                  next_crc_rx = crc_step(crc_rx, rx_data_in);               // RULE23
               end
            end else if ((rx_len != 8'h00) && (gap_cnt == 32'(GAP_CYCLES - 1))) begin
               next_rx_len = 8'h00;                                         // RULE23
               next_crc_rx = `MBDA_CRC_INIT;
               next_item   = 16'h0000;
               if (frame_ok) begin
                  next_state = (n_items != 16'h0000) ? MBDA_EXEC : MBDA_SEND;
                  next_tx_data  = req.addr;
                  next_tx_valid = (n_items == 16'h0000);
                  next_crc_tx   = `MBDA_CRC_INIT;
               end
            end
         end
         MBDA_EXEC: begin
            case (req.func)
               `MBDA_FC_WR_REG: w16_en = 1'b1;
               `MBDA_FC_WR_REGS: begin
                  w16_en   = 1'b1;                                          // RULE11
                  w16_addr = pos;
                  w16_data = {rxb(`MBDA_POS_DATA + {item[14:0], 1'b0}),
                              rxb(`MBDA_POS_DATA + {item[14:0], 1'b1})};
               end
               `MBDA_FC_WR_BIT: begin
                  bw_en  = 1'b1;
                  bw_val = (rxb(`MBDA_POS_VAL) == `MBDA_COIL_ON);           // RULE17
               end
               `MBDA_FC_WR_BITS: begin
                  bw_en   = 1'b1;                                           // RULE17
                  bw_addr = pos;
                  bw_val  = b8[item[2:0]];
               end
               default: ;
            endcase
            if (item == n_items - 16'h0001) begin
               next_state    = MBDA_SEND;
               next_item     = 16'h0000;
               next_tx_valid = 1'b1;
            end else begin
               next_item = item + 16'h0001;
            end
         end
         MBDA_SEND: begin
            if (tx_ready_in) begin
               if (item < resp_len) begin
                  next_crc_tx = crc_next;
               end
               if (item == resp_len + 16'h0001) begin
                  next_tx_valid = 1'b0;
                  next_state    = MBDA_RECV;
               end else begin
                  next_item = item + 16'h0001;
                  if (item + 16'h0001 < resp_len) begin
                     next_tx_data = resp_byte(item + 16'h0001);
                  end else if (item + 16'h0001 == resp_len) begin
                     next_tx_data = crc_next[7:0];                          // RULE23
                  end else begin
                     next_tx_data = crc_tx[15:8];
                  end
               end
            end
         end
         default: next_state = MBDA_RECV;
      endcase
   end

   // ----------
   // configuration storage
   // ----------
   always_comb begin
      next_cmd_bits  = cmd_bits;
      next_unit_code = unit_code;
      next_ceiling   = ceiling;
      next_smin      = smin;
      next_smax      = smax;
      next_setpoint  = setpoint;
      next_cfg_err   = cfg_err;
      if (w16_en) begin
         case (w16_addr)
            `MBDA_REG_CMD:     next_cmd_bits = w16_data;
            `MBDA_REG_UNIT: begin
               next_unit_code = w16_data;                                   // RULE6
               next_cfg_err   = (w16_data != `MBDA_UNIT_FEET) && (w16_data != `MBDA_UNIT_METERS);
            end
            `MBDA_REG_CEILING: next_ceiling = w16_data;                     // RULE1
            `MBDA_REG_SMIN:    next_smin = w16_data;                        // RULE2
            `MBDA_REG_SMAX:    next_smax = w16_data;
            default: ;                                                      // RULE5 RULE22
         endcase
      end
      if (bw_en && (bw_addr[15:4] == `MBDA_BITW_CMD)) begin
         next_cmd_bits[bw_addr[3:0]] = bw_val;                              // RULE8
      end
      if ((state == MBDA_EXEC) && (req.func == `MBDA_FC_WR_FLT) && (pos == `MBDA_FLT_SETPOINT)) begin
         next_setpoint = {rxb(`MBDA_POS_FDATA + {item[13:0], 2'b00}),       // RULE15 RULE16
                          rxb(`MBDA_POS_FDATA + {item[13:0], 2'b01}),
                          rxb(`MBDA_POS_FDATA + {item[13:0], 2'b10}),
                          rxb(`MBDA_POS_FDATA + {item[13:0], 2'b11})};      // RULE13
      end
   end

   // ----------
   // registers
   // ----------
   // buffer holds data only; validity is carried by rx_len
   always_ff @(posedge clk_in) begin
      if (rx_wr) begin
         rx_buf[rx_len[AW-1:0]] <= rx_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state     <= MBDA_RECV;
         rx_len    <= 8'h00;
         crc_rx    <= `MBDA_CRC_INIT;
         gap_cnt   <= 32'h0000_0000;
         item      <= 16'h0000;
         crc_tx    <= `MBDA_CRC_INIT;
         tx_data   <= 8'h00;
         tx_valid  <= 1'b0;
         cmd_bits  <= 16'h0000;
         unit_code <= `MBDA_UNIT_FEET;
         ceiling   <= `MBDA_CEILING_RST;
         smin      <= `MBDA_SMIN_RST;
         smax      <= `MBDA_SMAX_RST;
         setpoint  <= 32'h0000_0000;
         cfg_err   <= 1'b0;
      end else begin
         state     <= next_state;
         rx_len    <= next_rx_len;
         crc_rx    <= next_crc_rx;
         gap_cnt   <= next_gap_cnt;
         item      <= next_item;
         crc_tx    <= next_crc_tx;
         tx_data   <= next_tx_data;
         tx_valid  <= next_tx_valid;
         cmd_bits  <= next_cmd_bits;
         unit_code <= next_unit_code;
         ceiling   <= next_ceiling;
         smin      <= next_smin;
         smax      <= next_smax;
         setpoint  <= next_setpoint;
         cfg_err   <= next_cfg_err;
      end
   end

   assign tx_data_out       = tx_data;
   assign tx_valid_out      = tx_valid;
   assign cmd_bits_out      = cmd_bits;
   assign unit_code_out     = unit_code;
   assign level_scaled_out  = level_scaled;
   assign temp_setpoint_out = setpoint;
   assign config_error_out  = cfg_err;
endmodule // mbda_top

// ==== pkg/mbda_map.svh ====
// Purpose: constants of the modbus rtu data access block
// Assumes: one 50 MHz clock, bytes already framed by a uart outside
// Notes: included by its bare name; definitions only
//
// Notes on behaviour
// RULE1: integer data runs zero to a settable ceiling
// RULE2: engineering value scaled linearly between min and max
// RULE3: register read reply carries bytecount, big-endian words
// RULE4: out of scale returns ceiling plus one
// RULE5: writes to calculated values are accepted, ignored
// RULE6: host writes only valid codes; else config error
// RULE7: register 20 holds level unit, 44 is feet
// RULE8: sixteen status bits packed, also bit-accessible
// RULE9: register 5 bit 0 is critical low level
// RULE10: floats are ieee single, most significant byte first
// RULE11: float pairs read 03/04, write 16, high word first
// RULE12: temperature float pair at register 102
// RULE13: reserved floats read undefined, writes discarded
// RULE14: function 65 echoes count, four bytes per register; the code echoes the start address instead
// RULE15: function 66 writes four bytes, echoes count
// RULE16: float register 12 setpoint, register 1 temperature
// RULE17: bits read 1/2, write 5 single, 15 multiple
// RULE18: bit reply packs first bit in lsb
// RULE19: alarm bits 2..5 are level/temp alarms
// RULE20: answer only own address within 1..254
// RULE21: 01/02 and 03/04 share the same storage
// RULE22: reserved integer registers accepted, writes ignored
// RULE23: frames end with crc-16 and 3.5 char silence
// RULE24: silent on broadcast, foreign address, bad crc
`ifndef MBDA_MAP_SVH
`define MBDA_MAP_SVH
// function codes
`define MBDA_FC_RD_BITS   8'h01
`define MBDA_FC_RD_INBITS 8'h02
`define MBDA_FC_RD_REGS   8'h03
`define MBDA_FC_RD_INREGS 8'h04
`define MBDA_FC_WR_BIT    8'h05
`define MBDA_FC_WR_REG    8'h06
`define MBDA_FC_WR_BITS   8'h0F
`define MBDA_FC_WR_REGS   8'h10
`define MBDA_FC_RD_FLT    8'h41
`define MBDA_FC_WR_FLT    8'h42
// integer register space
`define MBDA_REG_LEVEL    16'h0000
`define MBDA_REG_ALARM    16'h0005
`define MBDA_REG_DIAG     16'h0006
`define MBDA_REG_CMD      16'h0007
`define MBDA_REG_UNIT     16'h0014
`define MBDA_REG_CEILING  16'h0015
`define MBDA_REG_SMIN     16'h0016
`define MBDA_REG_SMAX     16'h0017
`define MBDA_REG_TPAIR_HI 16'h0066
`define MBDA_REG_TPAIR_LO 16'h0067
// 32-bit float register space
`define MBDA_FLT_TEMP     16'h0001
`define MBDA_FLT_SETPOINT 16'h000C
// bit space: sixteen bits per packed word
`define MBDA_BITW_ALARM   12'h000
`define MBDA_BITW_DIAG    12'h001
`define MBDA_BITW_CMD     12'h002
// reset values and codes
`define MBDA_UNIT_FEET    16'h002C
`define MBDA_UNIT_METERS  16'h002D
`define MBDA_CEILING_RST  16'h270F
`define MBDA_SMIN_RST     16'h0000
`define MBDA_SMAX_RST     16'hFFFF
`define MBDA_COIL_ON      8'hFF
// frame layout
`define MBDA_POS_VAL      16'h0004
`define MBDA_POS_FDATA    16'h0006
`define MBDA_POS_DATA     16'h0007
`define MBDA_LEN_FIXED    16'h0008
`define MBDA_LEN_HDR      16'h0009
`define MBDA_LEN_MIN      8'h04
`define MBDA_MAX_ITEMS    16'h0020
`define MBDA_ADDR_MIN     8'h01
`define MBDA_ADDR_MAX     8'hFE
// crc and silent gap
`define MBDA_CRC_INIT     16'hFFFF
`define MBDA_CRC_POLY     16'hA001
`define MBDA_CHAR_BITS    11
`define MBDA_GAP_TENTHS   35
`define MBDA_TENTHS       10
`endif

// ==== pkg/mbda_pkg.sv ====
// Purpose: types of the modbus rtu data access block
// Assumes: nothing beyond the map header
// Notes: request fields are decoded from the receive buffer
package mbda_pkg;
   typedef enum logic [1:0] {MBDA_RECV, MBDA_EXEC, MBDA_SEND} mbda_state_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  func;
      logic [15:0] start;
      logic [15:0] count;
      logic [7:0]  bytes;
   } mbda_req_t;
endpackage

// ==== verif/mbda_host.sv ====
// Purpose: bus master model sending requests, collecting replies
// Assumes: one byte per two cycles
// Notes: slow mode drops tx_ready_out every other cycle, so each reply byte after the first waits one cycle
`timescale 1ns/1ps
module mbda_host (
   input  wire logic       clk_in,
   output logic      [7:0] rx_data_out,
   output logic            rx_valid_out,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_valid_in,
   output logic            tx_ready_out
);
   logic [7:0] rsp[$];
   logic       slow = 1'b0;
   logic       bad  = 1'b0;
   initial begin
      rx_data_out = 8'h00;
      rx_valid_out = 1'b0;
      tx_ready_out = 1'b1;
   end
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out) rsp.push_back(tx_data_in);
      tx_ready_out <= #1 !slow || !tx_ready_out;
   end
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c = 16'hFFFF;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] b[$]);
      logic [15:0] c;
      c = crc(b);
      b.push_back(c[7:0] ^ {8{bad}});
      b.push_back(c[15:8]);
      rsp.delete();
      foreach (b[i]) begin
         @(posedge clk_in);
         #1 rx_data_out = b[i];
         rx_valid_out = 1'b1;
         @(posedge clk_in);
         #1 rx_valid_out = 1'b0;
         rx_data_out = ~b[i];
      end
   endtask
endmodule // mbda_host

// ==== verif/mbda_monitor.sv ====
// Purpose: port assertions for mbda_top
// Assumes: silent gap of at least 8 cycles
// Notes: sees the top ports only
`timescale 1ns/1ps
module mbda_monitor (
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic [7:0]  slave_addr_in,
   input wire logic        rx_valid_in,
   input wire logic [7:0]  tx_data_out,
   input wire logic        tx_valid_out,
   input wire logic        tx_ready_in,
   input wire logic [15:0] cmd_bits_out,
   input wire logic [15:0] unit_code_out,
   input wire logic [31:0] temp_setpoint_out,
   input wire logic        config_error_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_rst; $rose(reset_n_in) |-> !tx_valid_out && unit_code_out == 16'h002C; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
   a_hold: assert property (p_hold) else $error("byte not held");
   property p_first; $rose(tx_valid_out) |-> tx_data_out == slave_addr_in; endproperty
   a_first: assert property (p_first) else $error("reply address");
   property p_bcast; slave_addr_in == 8'h00 || slave_addr_in == 8'hFF |-> !$rose(tx_valid_out); endproperty
   a_bcast: assert property (p_bcast) else $error("reply on broadcast");
   // a reply may only start after the silent interval
   property p_gap; rx_valid_in |=> (!$rose(tx_valid_out)) [*8]; endproperty
   a_gap: assert property (p_gap) else $error("reply inside gap");
   property p_cfg; $changed(unit_code_out) |-> config_error_out == !(unit_code_out inside {16'h002C, 16'h002D});
   endproperty
   a_cfg: assert property (p_cfg) else $error("config error flag");
   property p_setp; $changed(temp_setpoint_out) |-> ##[0:3] tx_valid_out; endproperty
   a_setp: assert property (p_setp) else $error("setpoint write unanswered");
   property p_cmd; $changed(cmd_bits_out) |-> ##[0:3] tx_valid_out; endproperty
   a_cmd: assert property (p_cmd) else $error("bit write unanswered");
endmodule // mbda_monitor
bind mbda_top mbda_monitor i_mbda_monitor (.*);

// ==== verif/tb_mbda_top.sv ====
// Purpose: self-checking bench for mbda_top
// Assumes: silent gap shortened to 20 cycles
// Notes: host model frames requests, bench judges replies
`timescale 1ns/1ps
module tb_mbda_top;
   logic        clk_in, reset_n_in, rx_valid_in, tx_valid_out, tx_ready_in, cfg_err;
   logic [7:0]  slave_addr_in, rx_data_in, tx_data_out, none[$];
   logic [15:0] level_eng_in, alarm_bits_in, cmd, unit, scaled;
   logic [31:0] setp;
   int          err_count = 0, check_count = 0;
   mbda_top #(.GAP_CYCLES(20)) i_mbda_top (.clk_in, .reset_n_in, .slave_addr_in, .level_eng_in,
      .temp_float_in(32'h42C80000), .alarm_bits_in, .diag_bits_in(16'h0000), .rx_data_in, .rx_valid_in,
      .tx_data_out, .tx_valid_out, .tx_ready_in, .cmd_bits_out(cmd), .unit_code_out(unit),
      .level_scaled_out(scaled), .temp_setpoint_out(setp), .config_error_out(cfg_err));
   mbda_host i_mbda_host (.clk_in, .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in),
      .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // silent cases wait the whole window, so keep them few
   task automatic txn(input logic [7:0] q[$], input logic [7:0] e[$]);
      logic [15:0] c;
      int          n = 0;
      c = i_mbda_host.crc(e);
      if (e.size() > 0) e = {e, c[7:0], c[15:8]};
      i_mbda_host.send(q);
      while (n < 300 && !(e.size() > 0 && i_mbda_host.rsp.size() == e.size() && !tx_valid_out)) begin
         @(posedge clk_in);
         #1 n++;
      end
      chk(32'(i_mbda_host.rsp.size()), 32'(e.size()));
      foreach (e[i]) if (i < i_mbda_host.rsp.size()) chk(32'(i_mbda_host.rsp[i]), 32'(e[i]));
      repeat (25) @(posedge clk_in);
   endtask
   task t_int;
      txn('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h27, 8'h0F});
      txn('{8'h01, 8'h04, 8'h00, 8'h14, 8'h00, 8'h01}, '{8'h01, 8'h04, 8'h02, 8'h00, 8'h2C});
      txn('{8'h01, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h0D});
      txn('{8'h01, 8'h06, 8'h00, 8'h16, 8'h01, 8'h00}, '{8'h01, 8'h06, 8'h00, 8'h16, 8'h01, 8'h00});
      level_eng_in = 16'h0050;
      txn('{8'h01, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34}, '{8'h01, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34});
      txn('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h27, 8'h10});
      chk(32'(scaled), 32'h2710);
      txn('{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h02, 8'h04, 8'h00, 8'h64, 8'h00, 8'h00},
          '{8'h01, 8'h10, 8'h00, 8'h15, 8'h00, 8'h02});
      txn('{8'h01, 8'h03, 8'h00, 8'h15, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h00, 8'h64, 8'h00, 8'h00});
   endtask
   task t_flt;
      i_mbda_host.slow = 1'b1;
      txn('{8'h01, 8'h03, 8'h00, 8'h66, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h42, 8'hC8, 8'h00, 8'h00});
      txn('{8'h01, 8'h41, 8'h00, 8'h01, 8'h00, 8'h01}, '{8'h01, 8'h41, 8'h00, 8'h01, 8'h42, 8'hC8, 8'h00, 8'h00});
      txn('{8'h01, 8'h42, 8'h00, 8'h0C, 8'h00, 8'h01, 8'h42, 8'hC8, 8'h00, 8'h00}, '{8'h01, 8'h42, 8'h00, 8'h01});
      chk(setp, 32'h42C80000);
      txn('{8'h01, 8'h42, 8'h00, 8'h0D, 8'h00, 8'h01, 8'h3F, 8'h80, 8'h00, 8'h00}, '{8'h01, 8'h42, 8'h00, 8'h01});
      chk(setp, 32'h42C80000);
      i_mbda_host.slow = 1'b0;
   endtask
   task t_bit;
      txn('{8'h01, 8'h02, 8'h00, 8'h02, 8'h00, 8'h04}, '{8'h01, 8'h02, 8'h01, 8'h03});
      txn('{8'h01, 8'h05, 8'h00, 8'h20, 8'hFF, 8'h00}, '{8'h01, 8'h05, 8'h00, 8'h20, 8'hFF, 8'h00});
      txn('{8'h01, 8'h0F, 8'h00, 8'h21, 8'h00, 8'h02, 8'h01, 8'h03}, '{8'h01, 8'h0F, 8'h00, 8'h21, 8'h00, 8'h02});
      txn('{8'h01, 8'h01, 8'h00, 8'h20, 8'h00, 8'h03}, '{8'h01, 8'h01, 8'h01, 8'h07});
      txn('{8'h01, 8'h03, 8'h00, 8'h07, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h07});
   endtask
   task t_sil;
      txn('{8'h01, 8'h06, 8'h00, 8'h14, 8'h00, 8'h63}, '{8'h01, 8'h06, 8'h00, 8'h14, 8'h00, 8'h63});
      chk(32'(cfg_err), 32'h1);
      txn('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, none);
      i_mbda_host.bad = 1'b1;
      txn('{8'h01, 8'h06, 8'h00, 8'h14, 8'h00, 8'h2D}, none);
      i_mbda_host.bad = 1'b0;
      slave_addr_in = 8'h00;
      txn('{8'h00, 8'h06, 8'h00, 8'h07, 8'h00, 8'h05}, none);
      chk(32'(cmd), 32'h7);
      chk(32'(unit), 32'h63);
   endtask
   task conclude;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      reset_n_in = 1'b0;
      slave_addr_in = 8'h01;
      level_eng_in = 16'hFFFF;
      alarm_bits_in = 16'h000D;
      repeat (3) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      chk(32'(unit), 32'h2C);
      t_int;
      t_flt;
      t_bit;
      t_sil;
      conclude;
   end
   initial begin
      #400000;
      err_count++;
      conclude;
   end
endmodule // tb_mbda_top
